// ==== rtl/baud_gen_pkg.sv ====
package baud_gen_pkg;

  // Register byte offsets on the Wishbone bus.
  localparam logic [7:0] PRESCALE_SEL_OFFS = 8'h00;
  localparam logic [7:0] DIVISOR_OFFS = 8'h04;
  localparam logic [7:0] MODE_OFFS = 8'h08;
  localparam logic [7:0] STATUS_OFFS = 8'h0c;
  localparam logic [7:0] TX_HOLD_OFFS = 8'h10;

  // Reset values.
  localparam logic [3:0] PRESCALE_SEL_RESET = 4'h0;
  localparam logic [7:0] DIVISOR_RESET = 8'hff;

  // Field positions in the mode and status registers.
  localparam int MODE_UNIT_BIT = 7;
  localparam int MODE_TX_BIT = 6;
  localparam int MODE_RX_BIT = 5;
  localparam int STATUS_HOLD_BIT = 1;
  localparam int STATUS_SHIFT_BIT = 0;

  // Prescaler codes and divisor limits.
  localparam logic [3:0] PRESCALE_EXT_CODE = 4'hb;
  localparam logic [3:0] PRESCALE_MAX_DIV_CODE = 4'ha;
  localparam logic [7:0] DIVISOR_MIN = 8'h08;

  // Timing counts in base clock periods and bits.
  localparam logic [1:0] TX_GAP_TICKS = 2'h2;
  localparam logic [3:0] FRAME_BITS = 4'hb;
  localparam int RX_MARGIN_TICKS = 2;

  // Enable bits of the mode register.
  typedef struct packed {
    logic unit_en;
    logic tx_en;
    logic rx_en;
  } mode_t;

  // Fill flags of the two transmit buffer stages.
  typedef struct packed {
    logic holding;
    logic shifter;
  } tx_flags_t;

  // Transmit sequencer states.
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SEND = 3'b010,
    TX_GAP = 3'b100
  } tx_state_t;

  // Divisor actually used: values under the minimum act as the minimum.
  function automatic logic [7:0] eff_divisor(input logic [7:0] k);
    eff_divisor = (k < DIVISOR_MIN) ? DIVISOR_MIN : k;
  endfunction

endpackage

// ==== rtl/half_rate_divider.sv ====
`timescale 1ns/1ps
// Divides base clock ticks by k and toggles a half-rate level on each
// reload, so one full period of the level spans 2k base ticks.
module half_rate_divider
  import baud_gen_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic tick_i,
  input wire logic [WIDTH-1:0] divisor_i,
  output logic half_o,
  output logic rise_o,
  output logic fall_o
);

  logic [WIDTH-1:0] cnt_q; // Base ticks counted since the last reload.
  logic half_q; // Half-rate level.
  logic reload; // Last tick of a k-tick span.

  // The span ends when the count reaches k minus one on a tick.
  assign reload = run_i && tick_i && (cnt_q == (divisor_i - 1'b1));
  assign half_o = half_q;
  assign rise_o = reload && !half_q;
  assign fall_o = reload && half_q;

  // Counter reloads after k ticks; restart or stop clears it.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      if (!run_i || restart_i) begin
        cnt_q <= '0;
      end else if (reload) begin
        cnt_q <= '0;
      end else if (tick_i) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // Level toggles at each reload, giving a period of 2k ticks.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      half_q <= 1'b0;
    end else if (ce_i) begin
      if (!run_i || restart_i) begin
        half_q <= 1'b0;
      end else if (reload) begin
        half_q <= !half_q;
      end
    end
  end

endmodule // half_rate_divider

// ==== rtl/uart_baud_rate_generator.sv ====
`timescale 1ns/1ps
module uart_baud_rate_generator
  import baud_gen_pkg::*;
#(
  parameter bit CHANNEL_ZERO = 1'b1, // Only channel zero has the pin.
  parameter int DIV_WIDTH = 8,
  parameter int PRESCALE_WIDTH = 10
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_clk_pin_i,
  input wire logic rx_start_i,
  output logic base_tick_o,
  output logic tx_data_o,
  output logic tx_frame_done_o,
  output logic rx_latch_o,
  output logic [3:0] rx_bit_index_o,
  output logic [2:0] mode_o
);

  logic [3:0] prescale_sel_q; // Base clock source code.
  logic [7:0] divisor_q; // Divisor k.
  mode_t mode_q; // Unit, transmit and receive enables.
  tx_flags_t flags_q; // Holding and shifter full flags.
  tx_state_t tx_state_q; // Transmit sequencer state.
  logic [7:0] hold_q; // Transmit holding register.
  logic [10:0] shift_q; // Frame being shifted out, LSB first.
  logic [3:0] tx_idx_q; // Bit of the frame now on the line.
  logic [1:0] gap_q; // Extra base ticks spent between frames.
  logic tx_q; // Transmit data level.
  logic done_q; // Frame completion pulse.
  logic rx_busy_q; // Receiver is timing a frame.
  logic [3:0] rx_idx_q; // Latch instants already given.
  logic rx_latch_q; // Registered latch pulse.
  logic ack_q; // Wishbone acknowledge.
  logic [31:0] rdat_q; // Wishbone read data.
  logic [PRESCALE_WIDTH-1:0] pre_cnt_q; // Main clock prescaler.
  logic ext_s1_q, ext_s2_q, ext_s3_q; // Pin synchroniser stages.
  logic ext_stable_q; // Accepted pin level.
  logic ext_rise; // Accepted rising edge on the pin.
  logic base_tick; // One main clock wide base clock pulse.
  logic div_tick; // Prescaler tap pulse.
  logic [7:0] k_eff; // Divisor after range clamp.
  logic req; // New bus request this cycle.
  logic wr_byte; // Write that carries the low byte lane.
  logic load; // Holding register moves into the shifter.
  logic tx_fall; // Transmit bit period ends.
  logic rx_rise; // Receive latch instant.
  logic tx_run; // Transmit divider running.
  logic rx_run; // Receive divider running.
  logic [31:0] rmux; // Read data before registering.

  // Low bits of the prescaler all ones give a tap at main/2^code.
  function automatic logic tap_hit(input logic [PRESCALE_WIDTH-1:0] cnt,
                                   input logic [3:0] code);
    logic [PRESCALE_WIDTH:0] m;
    m = ({{PRESCALE_WIDTH{1'b0}}, 1'b1} << code) - 1'b1;
    tap_hit = ((cnt & m[PRESCALE_WIDTH-1:0]) == m[PRESCALE_WIDTH-1:0]);
  endfunction

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  // Byte-wide registers take only writes that enable lane zero.
  assign wr_byte = req && wb_we_i && wb_sel_i[0];
  assign k_eff = eff_divisor(divisor_q);
  assign tx_run = mode_q.unit_en && mode_q.tx_en && (tx_state_q == TX_SEND);
  assign rx_run = mode_q.unit_en && mode_q.rx_en && rx_busy_q;
  assign load = flags_q.holding && base_tick &&
                ((tx_state_q == TX_IDLE) ||
                 ((tx_state_q == TX_GAP) && (gap_q == TX_GAP_TICKS - 1'b1)));

  // Prescaler counts main clocks only while the unit is on.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pre_cnt_q <= '0;
    end else if (ce_i) begin
      if (!mode_q.unit_en) begin
        pre_cnt_q <= '0;
      end else begin
        pre_cnt_q <= pre_cnt_q + 1'b1;
      end
    end
  end

  // Pin passes three stages; a change is taken when two and three agree.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      ext_stable_q <= 1'b0;
    end else if (ce_i) begin
      ext_s1_q <= ext_clk_pin_i;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      if (ext_s2_q == ext_s3_q) begin
        ext_stable_q <= ext_s3_q;
      end
    end
  end

  assign ext_rise = (ext_s2_q == ext_s3_q) && ext_s3_q && !ext_stable_q;
  assign div_tick = tap_hit(pre_cnt_q, prescale_sel_q);

  // Base clock source; reserved codes and a disabled unit give none.
  always_comb begin
    base_tick = 1'b0;
    if (mode_q.unit_en) begin
      if (prescale_sel_q <= PRESCALE_MAX_DIV_CODE) begin
        base_tick = div_tick;
      end else if (prescale_sel_q == PRESCALE_EXT_CODE) begin
        base_tick = CHANNEL_ZERO && ext_rise;
      end else begin
        base_tick = 1'b0;
      end
    end
  end

  assign base_tick_o = base_tick && ce_i;

  // Transmit divider restarts with each frame it times.
  half_rate_divider #(
    .WIDTH(DIV_WIDTH)
  ) tx_div (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .run_i(tx_run),
    .restart_i(load),
    .tick_i(base_tick),
    .divisor_i(k_eff),
    .half_o(),
    .rise_o(),
    .fall_o(tx_fall)
  );

  // Receive divider restarts on every start bit detection.
  half_rate_divider #(
    .WIDTH(DIV_WIDTH)
  ) rx_div (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .run_i(rx_run),
    .restart_i(rx_start_i),
    .tick_i(base_tick),
    .divisor_i(k_eff),
    .half_o(),
    .rise_o(rx_rise),
    .fall_o()
  );

  // Software registers; all state holds while ce_i is low.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      prescale_sel_q <= PRESCALE_SEL_RESET;
      divisor_q <= DIVISOR_RESET;
      mode_q <= '0;
    end else if (ce_i && wr_byte) begin
      case (wb_adr_i)
        PRESCALE_SEL_OFFS: begin
          prescale_sel_q <= wb_dat_i[3:0];
        end
        DIVISOR_OFFS: begin
          divisor_q <= wb_dat_i[7:0];
        end
        MODE_OFFS: begin
          mode_q.unit_en <= wb_dat_i[MODE_UNIT_BIT];
          mode_q.tx_en <= wb_dat_i[MODE_TX_BIT];
          mode_q.rx_en <= wb_dat_i[MODE_RX_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Holding register takes a byte written to its offset.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      hold_q <= '0;
    end else if (ce_i && wr_byte && (wb_adr_i == TX_HOLD_OFFS)) begin
      hold_q <= wb_dat_i[7:0];
    end
  end

  // Full flags: a write sets holding and wins over the move that clears it.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      flags_q <= '0;
    end else if (ce_i) begin
      if (!mode_q.unit_en || !mode_q.tx_en) begin
        flags_q <= '0;
      end else begin
        if (wr_byte && (wb_adr_i == TX_HOLD_OFFS)) begin
          flags_q.holding <= 1'b1;
        end else if (load) begin
          flags_q.holding <= 1'b0;
        end
        if (load) begin
          flags_q.shifter <= 1'b1;
        end else if (tx_fall && (tx_idx_q == FRAME_BITS - 1'b1) &&
                     !flags_q.holding) begin
          flags_q.shifter <= 1'b0;
        end
      end
    end
  end

  // Transmit sequencer with a two tick gap between chained frames.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tx_state_q <= TX_IDLE;
      gap_q <= '0;
    end else if (ce_i) begin
      if (!mode_q.unit_en || !mode_q.tx_en) begin
        tx_state_q <= TX_IDLE;
        gap_q <= '0;
      end else begin
        case (tx_state_q)
          TX_IDLE: begin
            if (load) begin
              tx_state_q <= TX_SEND;
            end
          end
          TX_SEND: begin
            if (tx_fall && (tx_idx_q == FRAME_BITS - 1'b1)) begin
              gap_q <= '0;
              tx_state_q <= flags_q.holding ? TX_GAP : TX_IDLE;
            end
          end
          TX_GAP: begin
            if (load) begin
              tx_state_q <= TX_SEND;
            end else if (base_tick) begin
              gap_q <= gap_q + 1'b1;
            end
          end
          default: begin
            tx_state_q <= TX_IDLE;
          end
        endcase
      end
    end
  end

  // Shifter builds start, data, even parity and stop, then shifts out.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      shift_q <= '1;
      tx_idx_q <= '0;
      tx_q <= 1'b1;
      done_q <= 1'b0;
    end else if (ce_i) begin
      done_q <= 1'b0;
      if (!mode_q.unit_en || !mode_q.tx_en) begin
        shift_q <= '1;
        tx_idx_q <= '0;
        tx_q <= 1'b1;
      end else if (load) begin
        shift_q <= {1'b1, ^hold_q, hold_q, 1'b0};
        tx_idx_q <= '0;
        tx_q <= 1'b0;
      end else if (tx_fall) begin
        if (tx_idx_q == FRAME_BITS - 1'b1) begin
          tx_idx_q <= '0;
          done_q <= 1'b1;
          tx_q <= 1'b1;
        end else begin
          shift_q <= {1'b1, shift_q[10:1]};
          tx_idx_q <= tx_idx_q + 1'b1;
          tx_q <= shift_q[1];
        end
      end
    end
  end

  // Receive timing: latch at the middle of each bit after the start.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rx_busy_q <= 1'b0;
      rx_idx_q <= '0;
      rx_latch_q <= 1'b0;
    end else if (ce_i) begin
      rx_latch_q <= 1'b0;
      if (!mode_q.unit_en || !mode_q.rx_en) begin
        rx_busy_q <= 1'b0;
        rx_idx_q <= '0;
      end else if (rx_start_i) begin
        rx_busy_q <= 1'b1;
        rx_idx_q <= '0;
      end else if (rx_rise) begin
        rx_latch_q <= 1'b1;
        if (rx_idx_q == FRAME_BITS - 1'b1) begin
          rx_busy_q <= 1'b0;
          rx_idx_q <= '0;
        end else begin
          rx_idx_q <= rx_idx_q + 1'b1;
        end
      end
    end
  end

  // Read data: byte registers in the low lane, upper bits zero.
  always_comb begin
    rmux = '0;
    case (wb_adr_i)
      PRESCALE_SEL_OFFS: rmux[3:0] = prescale_sel_q;
      DIVISOR_OFFS: rmux[7:0] = divisor_q;
      MODE_OFFS: begin
        rmux[MODE_UNIT_BIT] = mode_q.unit_en;
        rmux[MODE_TX_BIT] = mode_q.tx_en;
        rmux[MODE_RX_BIT] = mode_q.rx_en;
      end
      STATUS_OFFS: begin
        rmux[STATUS_HOLD_BIT] = flags_q.holding;
        rmux[STATUS_SHIFT_BIT] = flags_q.shifter;
      end
      default: rmux = '0;
    endcase
  end

  // Bus answers every request one cycle later, unmapped ones too.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else if (ce_i) begin
      ack_q <= req;
      if (req && !wb_we_i) begin
        rdat_q <= rmux;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign tx_data_o = tx_q;
  assign tx_frame_done_o = done_q;
  assign rx_latch_o = rx_latch_q;
  assign rx_bit_index_o = rx_idx_q;
  assign mode_o = mode_q;

endmodule // uart_baud_rate_generator

// ==== test/baud_gen_properties.sv ====
`timescale 1ns/1ps
// Watches bus timing, base clock gating and line and latch timing.
module baud_gen_properties
  import baud_gen_pkg::*;
#(
  parameter bit CHANNEL_ZERO = 1'b1,
  parameter int DIV_WIDTH = 8,
  parameter int PRESCALE_WIDTH = 10
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rx_start_i,
  input wire logic base_tick_o,
  input wire logic tx_data_o,
  input wire logic tx_frame_done_o,
  input wire logic rx_latch_o,
  input wire logic [2:0] mode_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // A request taken at this edge, and its read form.
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  wire logic rd = req && !wb_we_i;
  // The receive latch stays low for seven cycles.
  sequence s_quiet;
    !rx_latch_o [*7];
  endsequence
  // A prescale read followed by its answer.
  sequence s_presc_rd;
    rd && wb_adr_i == PRESCALE_SEL_OFFS ##1 wb_ack_o;
  endsequence
  AST_ACK_NEXT:
    assert property (req |=> wb_ack_o) else $error("No ack.");
  AST_ACK_PULSE:
    assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("Ack too long.");
  AST_RD_UPPER:
    assert property (rd |=> wb_dat_o[31:8] == 24'h0)
    else $error("Upper read bits set.");
  AST_PRESC_NIB:
    assert property (s_presc_rd |-> wb_dat_o[7:4] == 4'h0)
    else $error("Prescale upper nibble set.");
  AST_MODE_WR:
    assert property (req && wb_we_i && wb_sel_i[0] &&
      wb_adr_i == MODE_OFFS |=> mode_o == wb_dat_i[7:5])
    else $error("Mode not stored.");
  AST_TICK_GATED:
    assert property (!mode_o[2] |-> !base_tick_o)
    else $error("Tick while unit off.");
  AST_TX_IDLE:
    assert property (!mode_o[1] && ce_i |=> tx_data_o)
    else $error("Line not idle.");
  AST_TX_ON_TICK:
    assert property ($changed(tx_data_o) |->
      $past(base_tick_o) || mode_o[2:1] != 2'b11)
    else $error("Line moved off a tick.");
  AST_DONE_HIGH:
    assert property (tx_frame_done_o |-> tx_data_o)
    else $error("Done with line low.");
  AST_LATCH_SPACE:
    assert property (rx_latch_o && ce_i |=> s_quiet)
    else $error("Latches too close.");
  AST_START_QUIET:
    assert property (rx_start_i && mode_o[2] && mode_o[0] && ce_i
      |-> ##2 !rx_latch_o [*5]) else $error("Early latch.");
endmodule // baud_gen_properties

bind uart_baud_rate_generator baud_gen_properties #(
  .CHANNEL_ZERO(CHANNEL_ZERO), .DIV_WIDTH(DIV_WIDTH),
  .PRESCALE_WIDTH(PRESCALE_WIDTH)
) u_props (.mclk_i, .srst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_start_i,
  .base_tick_o, .tx_data_o, .tx_frame_done_o, .rx_latch_o, .mode_o);

// ==== test/serial_station.sv ====
`timescale 1ns/1ps
// Remote station: samples each frame of the line at bit centres.
module serial_station (
  input wire logic mclk_i,
  input wire logic line_i,
  input wire logic [31:0] bit_cyc_i,
  output logic [7:0] byte_o,
  output logic frame_ok_o,
  output logic [31:0] period_o,
  output logic [31:0] frames_o
);
  logic [10:0] bits; // Start, data LSB first, parity, stop.
  int now = 0; // Free cycle count.
  int last = 0; // Count at the previous start edge.
  always @(posedge mclk_i) now <= now + 1;
  // Waits for a start edge, then samples eleven bit centres.
  initial begin
    frames_o = 0;
    period_o = 0;
    forever begin
      @(negedge mclk_i iff line_i === 1'b0);
      period_o = now - last;
      last = now;
      for (int i = 0; i < 11; i++) begin
        repeat (i == 0 ? bit_cyc_i / 2 : bit_cyc_i) @(negedge mclk_i);
        bits[i] = line_i;
      end
      byte_o = bits[8:1];
      frame_ok_o = !bits[0] && bits[10] && !(^bits[9:1]);
      frames_o++;
    end
  end
endmodule // serial_station

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import baud_gen_pkg::*;
  logic clk, rst, ce, cyc, stb, we, ext, rxs; // Driven inputs.
  logic [7:0] adr;
  logic [31:0] dati, dato, q, bitc, per, nfr;
  logic ack, tick, txd, done, latch, sok, v;
  logic [3:0] idx, sel, bsel; // Bus lane enables driven, and their source.
  logic [2:0] mode;
  logic [7:0] sb;
  int failures, total_checks, ec, k, d0, d1, p0, nd;
  logic [7:0] expq[$]; // Bytes the line should carry, oldest first.

  uart_baud_rate_generator #(.CHANNEL_ZERO(1'b1), .DIV_WIDTH(8),
    .PRESCALE_WIDTH(10)) dut (.mclk_i(clk), .srst_i(rst), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dati), .wb_dat_o(dato), .wb_ack_o(ack),
    .ext_clk_pin_i(ext), .rx_start_i(rxs), .base_tick_o(tick),
    .tx_data_o(txd), .tx_frame_done_o(done), .rx_latch_o(latch),
    .rx_bit_index_o(idx), .mode_o(mode));
  serial_station far (.mclk_i(clk), .line_i(txd), .bit_cyc_i(bitc),
    .byte_o(sb), .frame_ok_o(sok), .period_o(per), .frames_o(nfr));

  // Compares one result and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One classic bus cycle; read data lands in q.
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dati <= d;
    sel <= bsel;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dato;
    if (n >= 50) failures++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // Reads a register and compares it.
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Polls status until the masked flags are clear.
  task automatic wait_stat(input logic [31:0] m);
    int n;
    n = 0;
    do begin
      wb(1'b0, STATUS_OFFS, 32'h0);
      n++;
    end while ((q & m) !== 32'h0 && n < 2000);
  endtask
  // Cycles between two base ticks.
  task automatic tick_per(output int p);
    p = 0;
    do @(negedge clk); while (tick !== 1'b1 && ++p < 5000);
    p = 0;
    do begin
      @(negedge clk);
      p++;
    end while (tick !== 1'b1 && p < 5000);
  endtask
  // Waits for frame n at the station and checks it against the model.
  task automatic got_frame(input int n, input int ep);
    int t;
    t = 0;
    while (nfr < n && t < 20000) begin
      @(negedge clk);
      t++;
    end
    if (t >= 20000) failures++;
    chk(sb, expq.pop_front());
    chk(sok, 1);
    if (ep > 0) chk(per, ep);
  endtask
  // Pulses a start detect, then times n latches against 2k.
  task automatic rx_go(input int n, output int f);
    int t, c, last;
    t = 0;
    c = 0;
    last = 0;
    f = 0;
    @(posedge clk) rxs <= 1'b1;
    @(posedge clk) rxs <= 1'b0;
    while (c < n && t < 9000) begin
      @(negedge clk);
      t++;
      if (latch === 1'b1) begin
        if (c == 0) f = t;
        else chk(t - last, 2 * k);
        last = t;
        c++;
      end
    end
    chk(c, n);
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // External pin toggles every five clocks.
  always @(posedge clk) begin
    ec <= (ec == 4) ? 0 : ec + 1;
    if (ec == 4) ext <= ~ext;
  end
  // Counts frame completion pulses, once each even across a freeze.
  always @(posedge clk) nd <= nd + (done === 1'b1 && ce === 1'b1);
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    wrap_up;
  end
  initial begin
    {rst, ce, cyc, stb, we, ext, rxs} = 7'b1100000;
    {adr, dati, ec, failures, total_checks, bitc, nd} = '0;
    {sel, bsel} = 8'h01;
    void'($urandom(32'h8f26));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdc(PRESCALE_SEL_OFFS, 32'h0);
    rdc(DIVISOR_OFFS, 32'hff);
    // A write without the low byte lane must leave the divisor alone.
    bsel = 4'he;
    wb(1'b1, DIVISOR_OFFS, 32'h55);
    bsel = 4'h1;
    rdc(DIVISOR_OFFS, 32'hff);
    rdc(MODE_OFFS, 32'h0);
    rdc(8'h40, 32'h0);
    // Codes 0 to 11; the unit is off while the code changes.
    for (int c = 0; c < 12; c++) begin
      wb(1'b1, MODE_OFFS, 32'h0);
      wb(1'b1, PRESCALE_SEL_OFFS, {24'h0, 4'($urandom), 4'(c)});
      rdc(PRESCALE_SEL_OFFS, 32'(c));
      wb(1'b1, MODE_OFFS, 32'h80);
      tick_per(p0);
      chk(p0, c == 11 ? 10 : 1 << c);
    end
    wb(1'b1, MODE_OFFS, 32'h0);
    p0 = 0;
    repeat (40) begin
      @(negedge clk);
      p0 += (tick === 1'b1);
    end
    chk(p0, 0);
    // Three back to back frames at divide by 8.
    k = 8 + $urandom % 4;
    bitc = 16 * k;
    wb(1'b1, PRESCALE_SEL_OFFS, 32'h3);
    wb(1'b1, DIVISOR_OFFS, k);
    wb(1'b1, MODE_OFFS, 32'hc0);
    repeat (3) expq.push_back(8'($urandom));
    tick_per(p0);
    wb(1'b1, TX_HOLD_OFFS, {24'h0, expq[0]});
    rdc(STATUS_OFFS, 32'h2);
    wait_stat(32'h2);
    chk(q, 32'h1);
    wb(1'b1, TX_HOLD_OFFS, {24'h0, expq[1]});
    rdc(STATUS_OFFS, 32'h3);
    wait_stat(32'h2);
    wb(1'b1, TX_HOLD_OFFS, {24'h0, expq[2]});
    // Stop the clock for 31 edges inside the second frame.
    @(posedge clk) ce <= 1'b0;
    @(negedge clk) v = txd;
    repeat (30) begin
      @(negedge clk);
      chk(txd, v);
    end
    @(posedge clk) ce <= 1'b1;
    rdc(DIVISOR_OFFS, k);
    got_frame(1, 0);
    got_frame(2, 11 * bitc + 16);
    got_frame(3, 11 * bitc + 47);
    wait_stat(32'h3);
    chk(q, 32'h0);
    chk(nd, 3);
    // Receive latches at full rate, then restarts.
    k = 8 + $urandom % 8;
    wb(1'b1, MODE_OFFS, 32'h0);
    wb(1'b1, PRESCALE_SEL_OFFS, 32'h0);
    wb(1'b1, DIVISOR_OFFS, k);
    wb(1'b1, MODE_OFFS, 32'ha0);
    chk(mode, 3'b101);
    rx_go(11, d0);
    @(negedge clk);
    // The index returns to zero once the last latch of a frame is given.
    chk(idx, 0);
    rx_go(3, d1);
    chk(idx, 3);
    rx_go(11, p0);
    chk(d1, d0);
    chk(p0, d0);
    wrap_up;
  end
endmodule // tb_top
